// ### hw/rptrc_top.sv
// Receive path tandem and ring control block with its count registers.
// Summary of operation
// - Flag loss-of-multiframe changes; clear on read.
// - Tandem mode inserts previous error count, data link.
// - Tandem mode recomputes path parity after Z5 change.
// - Pointer loss or AIS in tandem mode: hold pointer, fail payload.
// - Tandem mode off passes payload unmodified.
// - Failure forcing in tandem mode fails payload.
// - Accumulate error field, or absolute difference.
// - Optionally exclude fixed stuff from path parity on non-concatenated streams.
// - Block parity counts at most one error.
// - Bad size bits suppress offset indications when enabled.
// - Bad size bits always flag invalid pointer.
// - Justification needs three frames since last change.
// - Keep sixteen-bit tandem incoming error total.
// - Trigger write snapshots total and restarts accumulator.
// - Count positive justifications on selected stream.
// - Count negative justifications on selected stream.
// - Trigger write snapshots justification counts, restarts.
// - Interrupt enable gates multiframe loss interrupt.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module rptrc_top #(
  parameter int IEC_WIDTH = 16, // Width of the incoming error total.
  parameter int JUST_WIDTH = 8 // Width of each justification counter.
) (
  input wire logic mclk, // Processor clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  // Avalon-MM slave.
  input wire logic [9:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall while the answer is pending.
  // Receive stream, one byte per cycle.
  input wire logic [7:0] rx_data, // Receive byte.
  input wire logic rx_valid, // Byte strobe.
  input wire logic rx_frame_start, // First byte of a frame.
  input wire logic rx_is_h1, // Byte is H1.
  input wire logic rx_is_h2, // Byte is H2.
  input wire logic rx_is_b3, // Byte is B3.
  input wire logic rx_is_z5, // Byte is Z5.
  input wire logic rx_is_spe, // Byte belongs to the payload envelope.
  input wire logic rx_is_fixed_stuff, // Byte is a fixed stuff column.
  input wire logic rx_concat, // Stream is a concatenated STS-3c.
  input wire logic rx_pointer_loss, // Loss of pointer or path AIS.
  input wire logic [1:0] rx_size_bits, // Size bits of the pointer.
  input wire logic rx_ndf_raw, // New data flag before qualifying.
  input wire logic rx_inc_raw, // Increment before qualifying.
  input wire logic rx_dec_raw, // Decrement before qualifying.
  input wire logic [3:0] tandem_overhead_input, // Tandem data link.
  input wire logic multiframe_loss, // Loss-of-multiframe state.
  input wire logic drop_pos_just, // Positive justification on DROP.
  input wire logic drop_neg_just, // Negative justification on DROP.
  // DROP bus and indications.
  output logic [7:0] drop_data, // DROP byte.
  output logic drop_valid, // DROP byte strobe.
  output logic ndf_enable, // Qualified new data flag.
  output logic inc_ind, // Qualified increment.
  output logic dec_ind, // Qualified decrement.
  output logic inv_point, // Invalid pointer.
  output logic [3:0] parity_errors, // Errors reported per frame.
  output logic interrupt_out_n // Interrupt, active low.
);
  // All state of the block.
  typedef struct packed {
    logic [7:0] ctrl; // Tandem ring control register.
    logic irq_en; // Loss-of-multiframe interrupt enable.
    logic mf_flag; // Loss-of-multiframe change flag.
    logic mf_prev; // Loss state seen last cycle.
    logic mon_sel; // Justification monitor select.
    logic [3:0] trig_cnt; // Snapshot delay after a trigger.
    logic trig_busy; // A transfer is pending.
    logic [7:0] parity; // Running parity of the current frame.
    logic [7:0] rx_b3; // B3 received in this frame.
    logic [3:0] prev_err; // Parity errors of the previous frame.
    logic [7:0] out_parity; // Parity of the modified output frame.
    logic [7:0] h1; // Last good H1.
    logic [7:0] h2; // Last good H2.
    logic [1:0] since_change; // Frames since an offset change.
    logic [7:0] dout; // DROP byte.
    logic dvalid; // DROP strobe.
    logic ndf; // Qualified new data flag.
    logic inc; // Qualified increment.
    logic dec; // Qualified decrement.
    logic inv; // Invalid pointer.
    logic [3:0] perr; // Reported parity errors.
    logic [31:0] rdata; // Read data.
    logic ack; // Read or write answered.
  } rptrc_state_t;
  rptrc_state_t s_q;
  rptrc_state_t s_d;
  logic [7:0] idx; // Register index from the byte address.
  logic snap; // Snapshot strobe to the counters.
  logic [IEC_WIDTH-1:0] iec_inc; // Incoming error amount to add.
  logic [JUST_WIDTH-1:0] pos_inc; // Positive justification amount.
  logic [JUST_WIDTH-1:0] neg_inc; // Negative justification amount.
  logic [IEC_WIDTH-1:0] iec_snap; // Snapshot of the error total.
  logic [JUST_WIDTH-1:0] pos_snap; // Snapshot of positive count.
  logic [JUST_WIDTH-1:0] neg_snap; // Snapshot of negative count.
  logic tandem; // Originating tandem mode active.
  logic fail; // Payload is forced to incoming failure.
  logic [7:0] mism; // Parity mismatch bits at B3.
  logic [3:0] nerr; // Parity errors found at B3.
  logic [3:0] rx_iec; // Incoming error field received in Z5.
  logic [7:0] z5_out; // Rebuilt Z5 byte.
  logic [7:0] byte_out; // Output byte before registering.
  logic just_ok; // Spacing test passed.
  logic size_ok; // Size bits are valid.

  // Counts the set bits of a mismatch byte.
  function automatic logic [3:0] rptrc_popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : rptrc_popcount

  assign idx = avs_address[9:2];
  assign tandem = s_q.ctrl[rptrc_pkg::CTL_ORIG_TANDEM];
  // The failure force acts only in tandem mode.
  assign fail = tandem & (rx_pointer_loss |
    s_q.ctrl[rptrc_pkg::CTL_FAIL_FORCE]);
  assign size_ok = (rx_size_bits == rptrc_pkg::SIZE_BITS_VALID);
  assign just_ok = ~s_q.ctrl[rptrc_pkg::CTL_JUST_SPACING] |
    (s_q.since_change >= rptrc_pkg::JUST_SPACING_FRAMES);
  assign rx_iec = rx_data[rptrc_pkg::Z5_IEC_LSB +: 4];

  // Mismatch between the received B3 and the frame parity.
  always_comb begin
    mism = rx_data ^ s_q.parity;
    if (s_q.ctrl[rptrc_pkg::CTL_BLOCK_PARITY]) begin
      nerr = {3'h0, |mism};
    end else begin
      nerr = rptrc_popcount(mism);
    end
  end

  // Rebuilt Z5: error field and the tandem data link.
  always_comb begin
    z5_out = 8'h00;
    z5_out[rptrc_pkg::Z5_DL_LSB +: 4] = tandem_overhead_input;
    if (fail) begin
      z5_out[rptrc_pkg::Z5_IEC_LSB +: 4] =
        rptrc_pkg::IEC_FAIL_CODE;
    end else begin
      z5_out[rptrc_pkg::Z5_IEC_LSB +: 4] = s_q.prev_err;
    end
  end

  // Chooses the DROP byte for the current receive byte.
  always_comb begin
    byte_out = rx_data;
    if (!tandem) begin
      byte_out = rx_data;
    end else if (rx_is_h1) begin
      byte_out = fail ? s_q.h1 : rx_data;
    end else if (rx_is_h2) begin
      byte_out = fail ? s_q.h2 : rx_data;
    end else if (rx_is_z5) begin
      byte_out = z5_out;
    end else if (rx_is_b3) begin
      // Received B3 corrected for earlier changes, or error free.
      byte_out = fail ? s_q.out_parity :
        (rx_data ^ s_q.parity ^ s_q.out_parity);
    end else if (rx_is_spe && fail) begin
      byte_out = 8'hff;
    end
  end

  // Amounts added to the counters in this cycle.
  always_comb begin
    iec_inc = '0;
    if (rx_valid && rx_is_z5) begin
      if (s_q.ctrl[rptrc_pkg::CTL_COUNT_DIFF]) begin
        iec_inc[3:0] = (s_q.prev_err > rx_iec) ?
          (s_q.prev_err - rx_iec) : (rx_iec - s_q.prev_err);
      end else begin
        iec_inc[3:0] = rx_iec;
      end
    end
    pos_inc = '0;
    neg_inc = '0;
    pos_inc[0] = s_q.mon_sel ? s_q.inc : drop_pos_just;
    neg_inc[0] = s_q.mon_sel ? s_q.dec : drop_neg_just;
  end

  assign snap = s_q.trig_busy && (s_q.trig_cnt == 4'h0);

  // Next-state logic for registers, stream and pointer qualifiers.
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    // Transfer countdown after a trigger write.
    if (snap) begin
      s_d.trig_busy = 1'b0;
    end else if (s_q.trig_busy) begin
      s_d.trig_cnt = s_q.trig_cnt - 4'h1;
    end
    // A write lands at the edge at which waitrequest is seen low.
    if (avs_write && s_q.ack) begin
      if (avs_byteenable[0]) begin
        case (idx)
          rptrc_pkg::IDX_TANDEM_CTRL: begin
            s_d.ctrl = avs_writedata[7:0] & rptrc_pkg::CTL_WRITE_MASK;
          end
          rptrc_pkg::IDX_MF_STATUS: begin
            s_d.irq_en = avs_writedata[rptrc_pkg::MF_IRQ_ENABLE];
          end
          rptrc_pkg::IDX_MASTER_CFG: begin
            s_d.mon_sel = avs_writedata[rptrc_pkg::CFG_MONITOR_SELECT];
          end
          rptrc_pkg::IDX_ACC_TRIGGER: begin
            s_d.trig_busy = 1'b1;
            s_d.trig_cnt = rptrc_pkg::TRANSFER_DELAY;
          end
          default: begin
            s_d.ctrl = s_q.ctrl; // Other writes are ignored.
          end
        endcase
      end
    end
    // Register access answers one cycle after the request.
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0;
      if (avs_read) begin
        case (idx)
          rptrc_pkg::IDX_TANDEM_CTRL: s_d.rdata[7:0] = s_q.ctrl;
          rptrc_pkg::IDX_IEC_LOW: s_d.rdata[7:0] = iec_snap[7:0];
          rptrc_pkg::IDX_IEC_HIGH: s_d.rdata[7:0] = iec_snap[15:8];
          rptrc_pkg::IDX_POS_JUST: s_d.rdata[7:0] = pos_snap;
          rptrc_pkg::IDX_NEG_JUST: s_d.rdata[7:0] = neg_snap;
          rptrc_pkg::IDX_MASTER_CFG: s_d.rdata[0] = s_q.mon_sel;
          rptrc_pkg::IDX_MF_STATUS: begin
            s_d.rdata[rptrc_pkg::MF_CHANGE_FLAG] = s_q.mf_flag;
            s_d.rdata[rptrc_pkg::MF_LOSS_STATE] = multiframe_loss;
            s_d.rdata[rptrc_pkg::MF_IRQ_ENABLE] = s_q.irq_en;
            s_d.mf_flag = 1'b0; // Read clears the flag.
          end
          default: s_d.rdata = 32'h0; // Unmapped reads give zero.
        endcase
      end
    end
    // A change in the same cycle as the clearing read still sets.
    s_d.mf_prev = multiframe_loss;
    if (multiframe_loss != s_q.mf_prev) begin
      s_d.mf_flag = 1'b1;
    end
    // Pointer qualifiers, one result per frame pointer.
    s_d.ndf = 1'b0;
    s_d.inc = 1'b0;
    s_d.dec = 1'b0;
    s_d.inv = 1'b0;
    if (rx_valid && rx_is_h2) begin
      s_d.inv = ~size_ok;
      if (size_ok || !s_q.ctrl[rptrc_pkg::CTL_SIZE_CHECK]) begin
        s_d.ndf = rx_ndf_raw;
        s_d.inc = rx_inc_raw & just_ok;
        s_d.dec = rx_dec_raw & just_ok;
      end
      if (!rx_pointer_loss) begin
        s_d.h2 = rx_data; // Keep the last good pointer.
      end
    end
    if (rx_valid && rx_is_h1 && !rx_pointer_loss) begin
      s_d.h1 = rx_data;
    end
    // Frame spacing counter, restarted by any accepted offset change.
    if (s_q.ndf || s_q.inc || s_q.dec) begin
      s_d.since_change = 2'h0;
    end else if (rx_valid && rx_frame_start &&
                 s_q.since_change != rptrc_pkg::JUST_SPACING_FRAMES) begin
      s_d.since_change = s_q.since_change + 2'h1;
    end
    // Path parity over the payload, stuff columns optional unless concatenated.
    if (rx_valid) begin
      if (rx_is_b3) begin
        s_d.perr = nerr;
        s_d.prev_err = nerr; // Inserted into the next Z5.
      end
      if (rx_frame_start) begin
        s_d.parity = 8'h00;
        s_d.out_parity = 8'h00;
      end else if (rx_is_spe && !rx_is_b3 &&
                   !(rx_is_fixed_stuff && !rx_concat &&
                     s_q.ctrl[rptrc_pkg::CTL_FIXED_STUFF])) begin
        s_d.parity = s_q.parity ^ rx_data;
        s_d.out_parity = s_q.out_parity ^ byte_out;
      end
    end
    s_d.dvalid = rx_valid;
    s_d.dout = rx_valid ? byte_out : s_q.dout;
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= rptrc_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Tandem incoming error total.
  rptrc_counter #(.WIDTH(IEC_WIDTH)) u_iec (
    .mclk(mclk), .rst(rst), .inc(iec_inc), .snap(snap),
    .snapshot(iec_snap)
  );
  // Positive justification count.
  rptrc_counter #(.WIDTH(JUST_WIDTH)) u_pos (
    .mclk(mclk), .rst(rst), .inc(pos_inc), .snap(snap),
    .snapshot(pos_snap)
  );
  // Negative justification count.
  rptrc_counter #(.WIDTH(JUST_WIDTH)) u_neg (
    .mclk(mclk), .rst(rst), .inc(neg_inc), .snap(snap),
    .snapshot(neg_snap)
  );

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign drop_data = s_q.dout;
  assign drop_valid = s_q.dvalid;
  assign ndf_enable = s_q.ndf;
  assign inc_ind = s_q.inc;
  assign dec_ind = s_q.dec;
  assign inv_point = s_q.inv;
  assign parity_errors = s_q.perr;
  assign interrupt_out_n = ~(s_q.irq_en & s_q.mf_flag);
endmodule : rptrc_top

// ### hw/rptrc_pkg.sv
// Package of offsets, field positions, reset values and timing constants.
package rptrc_pkg;
  // Register offsets: the printed offsets are not all multiples of four,
  // so each is an index and the byte address is four times the index.
  localparam logic [7:0] IDX_TANDEM_CTRL = 8'h1d; // Tandem ring control.
  localparam logic [7:0] IDX_IEC_LOW = 8'h1e; // Incoming error total low.
  localparam logic [7:0] IDX_IEC_HIGH = 8'h1f; // Incoming error total high.
  localparam logic [7:0] IDX_POS_JUST = 8'h24; // Positive justifications.
  localparam logic [7:0] IDX_NEG_JUST = 8'h25; // Negative justifications.
  localparam logic [7:0] IDX_MF_STATUS = 8'h1c; // Multiframe status/control.
  localparam logic [7:0] IDX_ACC_TRIGGER = 8'h30; // Accumulation trigger.
  localparam logic [7:0] IDX_MASTER_CFG = 8'h31; // Master configuration.
  // Field positions in the tandem ring control register.
  localparam int CTL_ORIG_TANDEM = 0; // Originating tandem mode.
  localparam int CTL_FAIL_FORCE = 1; // Incoming failure forcing.
  localparam int CTL_COUNT_DIFF = 2; // Count difference mode.
  localparam int CTL_FIXED_STUFF = 4; // Fixed stuff exclusion.
  localparam int CTL_BLOCK_PARITY = 5; // Block parity mode.
  localparam int CTL_SIZE_CHECK = 6; // Size check enable.
  localparam int CTL_JUST_SPACING = 7; // Justification spacing enable.
  // Writable bits of the control register; bit 3 is unused.
  localparam logic [7:0] CTL_WRITE_MASK = 8'hf7;
  localparam logic [7:0] CTL_RESET = 8'h00; // Control value after reset.
  // Field positions in the multiframe status register.
  localparam int MF_CHANGE_FLAG = 7; // Loss-of-multiframe change flag.
  localparam int MF_LOSS_STATE = 6; // Current loss-of-multiframe state.
  localparam int MF_IRQ_ENABLE = 5; // Loss-of-multiframe irq enable.
  localparam int CFG_MONITOR_SELECT = 0; // Justification monitor select.
  // Incoming error code that signals incoming signal failure.
  localparam logic [3:0] IEC_FAIL_CODE = 4'hf;
  // Valid size-bit pattern of the payload pointer.
  localparam logic [1:0] SIZE_BITS_VALID = 2'h2;
  // Frames since the last offset change before a justification counts.
  localparam logic [1:0] JUST_SPACING_FRAMES = 2'h3;
  // Snapshot transfer deadline in processor-clock cycles.
  localparam int TRANSFER_MAX_CYCLES = 12;
  // Transfer pipeline latency, well inside the deadline.
  localparam logic [3:0] TRANSFER_DELAY = 4'h2;
  // Z5 field layout: error count in the high nibble, data link in the low.
  localparam int Z5_IEC_LSB = 4;
  localparam int Z5_DL_LSB = 0;
endpackage : rptrc_pkg

// ### hw/rptrc_counter.sv
// Saturating interval counter with snapshot transfer.
`timescale 1ns/1ps
module rptrc_counter #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inc, // Amount added this cycle.
  input wire logic snap, // One-cycle snapshot and restart strobe.
  output logic [WIDTH-1:0] snapshot // Readable count of last interval.
);
  // All state of the counter.
  typedef struct packed {
    logic [WIDTH-1:0] acc; // Running interval total.
    logic [WIDTH-1:0] snap; // Held snapshot.
  } rptrc_cnt_t;
  rptrc_cnt_t s_q;
  rptrc_cnt_t s_d;
  logic [WIDTH:0] sum; // Sum with carry for the saturation test.

  // Next-state logic: add with saturation, or snapshot and restart.
  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.acc} + {1'b0, inc};
    if (snap) begin
      // The whole word is copied at once, so both bytes match.
      s_d.snap = s_q.acc;
      s_d.acc = inc; // Restart from zero, keeping this cycle's event.
    end else if (sum[WIDTH]) begin
      s_d.acc = '1; // Hold at full scale instead of wrapping.
    end else begin
      s_d.acc = sum[WIDTH-1:0];
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign snapshot = s_q.snap;
endmodule : rptrc_counter

// ### testbench/rptrc_sva.sv
// Checker of bus wait states, stream latency and pointer indications.
`timescale 1ns/1ps
module rptrc_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic rx_is_h2,
  input wire logic [1:0] rx_size_bits,
  input wire logic rx_ndf_raw,
  input wire logic rx_inc_raw,
  input wire logic rx_dec_raw,
  input wire logic drop_valid,
  input wire logic ndf_enable,
  input wire logic inc_ind,
  input wire logic dec_ind,
  input wire logic inv_point,
  input wire logic [3:0] parity_errors
);
  // All checks run on the processor clock and pause during reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Raw pointer events seen on an H2 byte.
  logic h2, h2_ndf, h2_inc, h2_dec;
  assign h2 = rx_valid & rx_is_h2;
  assign h2_ndf = h2 & rx_ndf_raw;
  assign h2_inc = h2 & rx_inc_raw;
  assign h2_dec = h2 & rx_dec_raw;
  chk_wait_first: assert property (
    $rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("request answered without a wait cycle");
  chk_wait_one: assert property (
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  chk_read_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_drop_follow: assert property (
    1'h1 |=> drop_valid == $past(rx_valid))
    else $error("drop strobe does not follow receive strobe");
  chk_size_invalid: assert property (
    h2 && rx_size_bits != rptrc_pkg::SIZE_BITS_VALID |=> inv_point)
    else $error("bad size bits without invalid pointer");
  chk_inc_cause: assert property (inc_ind |-> $past(h2_inc))
    else $error("increment without raw increment");
  chk_dec_cause: assert property (dec_ind |-> $past(h2_dec))
    else $error("decrement without raw decrement");
  chk_ndf_cause: assert property (ndf_enable |-> $past(h2_ndf))
    else $error("new data flag without raw flag");
  chk_parity_max: assert property (parity_errors <= 4'h8)
    else $error("more parity errors than bits");
endmodule : rptrc_sva
bind rptrc_top rptrc_sva u_sva (.mclk, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .rx_valid, .rx_is_h2, .rx_size_bits,
  .rx_ndf_raw, .rx_inc_raw, .rx_dec_raw, .drop_valid, .ndf_enable,
  .inc_ind, .dec_ind, .inv_point, .parity_errors);

// ### testbench/rptrc_drop_peer.sv
// Model of the downstream DROP bus logic that makes justification pulses.
`timescale 1ns/1ps
module rptrc_drop_peer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] drop_data,
  input wire logic drop_valid,
  output logic drop_pos_just,
  output logic drop_neg_just
);
  // Bytes taken from the DROP bus.
  int n_bytes = 0;
  always @(posedge mclk) begin
    if (!rst && drop_valid) begin
      n_bytes <= n_bytes + 1;
    end
  end
  // Pulses are idle from time zero.
  initial begin
    drop_pos_just = 1'h0;
    drop_neg_just = 1'h0;
  end
  // Sends np positive and nn negative one-cycle pulses, gaps between.
  task automatic pulse(input logic [2:0] np, input logic [2:0] nn);
    for (int i = 0; i < 14; i++) begin
      @(posedge mclk);
      drop_pos_just <= (i < 2 * np) && !i[0];
      drop_neg_just <= (i < 2 * nn) && !i[0];
    end
  endtask : pulse
endmodule : rptrc_drop_peer

// ### testbench/tb.sv
// Self-checking bench for the receive tandem ring control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb;
  localparam logic [7:0] CT = rptrc_pkg::IDX_TANDEM_CTRL;
  localparam logic [7:0] MF = rptrc_pkg::IDX_MF_STATUS;
  // Bench-driven inputs, idle at time zero except rst, which starts asserted.
  logic mclk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  logic [9:0] avs_address = 10'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0, tandem_overhead_input = 4'h0;
  logic [7:0] rx_data = 8'h0;
  logic [1:0] rx_size_bits = 2'h0;
  logic rx_valid = 1'h0, rx_frame_start = 1'h0, rx_is_h1 = 1'h0;
  logic rx_is_h2 = 1'h0, rx_is_b3 = 1'h0, rx_is_z5 = 1'h0, rx_is_spe = 1'h0;
  logic rx_is_fixed_stuff = 1'h0, rx_concat = 1'h0, rx_pointer_loss = 1'h0;
  logic rx_ndf_raw = 1'h0, rx_inc_raw = 1'h0, rx_dec_raw = 1'h0;
  logic multiframe_loss = 1'h0;
  // Design outputs.
  logic [31:0] avs_readdata;
  logic [7:0] drop_data;
  logic [3:0] parity_errors;
  logic avs_waitrequest, drop_valid, ndf_enable, inc_ind, dec_ind;
  logic inv_point, interrupt_out_n, drop_pos_just, drop_neg_just;
  // Counters, control model and captured results.
  int err_count = 0, n_checks = 0, cycles = 0, sum;
  logic [7:0] ctrl_m, rd, got_d, dv;
  logic [3:0] got_i, nib;
  logic [2:0] np, nn;
  rptrc_top u_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .rx_data, .rx_valid, .rx_frame_start, .rx_is_h1, .rx_is_h2, .rx_is_b3,
    .rx_is_z5, .rx_is_spe, .rx_is_fixed_stuff, .rx_concat, .rx_pointer_loss,
    .rx_size_bits, .rx_ndf_raw, .rx_inc_raw, .rx_dec_raw,
    .tandem_overhead_input, .multiframe_loss, .drop_pos_just, .drop_neg_just,
    .drop_data, .drop_valid, .ndf_enable, .inc_ind, .dec_ind, .inv_point,
    .parity_errors, .interrupt_out_n);
  rptrc_drop_peer u_peer (.mclk, .rst, .drop_data, .drop_valid,
    .drop_pos_just, .drop_neg_just);
  // The 100 MHz processor clock.
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Cuts a hung run short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // One Avalon transfer; holds the request until waitrequest is low.
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] q);
    @(posedge mclk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= {4{wr}};
    {avs_write, avs_read} <= {wr, !wr};
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata[7:0];
    {avs_write, avs_read} <= 2'h0;
  endtask : bus
  // Reads one register and compares it.
  task automatic rchk(input logic [7:0] idx, input logic [7:0] ex,
                      input string nm);
    bus(1'h0, idx, 8'h0, rd);
    `CHK(nm, ex, rd)
  endtask : rchk
  // Trigger write, then the full transfer deadline.
  task automatic trig();
    bus(1'h1, rptrc_pkg::IDX_ACC_TRIGGER, 8'h1, rd);
    repeat (rptrc_pkg::TRANSFER_MAX_CYCLES) @(posedge mclk);
  endtask : trig
  // One receive byte: k 0 payload, 1 Z5, 2 H2, 3 frame start.
  task automatic send(input logic [7:0] d, input logic [1:0] k,
                      input logic [1:0] ss, input logic [2:0] raw);
    @(posedge mclk);
    {rx_valid, rx_data, rx_frame_start, rx_is_h2, rx_is_z5, rx_is_spe} <=
      {1'h1, d, k == 2'h3, k == 2'h2, k == 2'h1, k == 2'h0};
    {rx_size_bits, rx_ndf_raw, rx_inc_raw, rx_dec_raw} <= {ss, raw};
    @(posedge mclk);
    {rx_valid, rx_frame_start} <= 2'h0;
    @(posedge mclk);
    got_d = drop_data;
    got_i = {ndf_enable, inc_ind, dec_ind, inv_point};
  endtask : send
  // Expected DROP byte: failure fills payload and marks Z5.
  function automatic logic [7:0] model(input logic [7:0] d,
                                       input logic [1:0] k, input logic pl);
    logic fail;
    fail = ctrl_m[0] & (pl | ctrl_m[1]);
    if (fail && k == 2'h0) return 8'hff;
    if (ctrl_m[0] && k == 2'h1) return {{4{fail}}, tandem_overhead_input};
    return d;
  endfunction : model
  initial begin
    void'($urandom(32'hbea62c27));
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    rchk(CT, rptrc_pkg::CTL_RESET, "ctrl reset");
    bus(1'h1, CT, 8'hff, rd);
    rchk(CT, rptrc_pkg::CTL_WRITE_MASK, "ctrl mask");
    rchk(8'h3f, 8'h0, "unmapped");
    $display("done: registers");
    // Every mix of tandem mode, failure forcing and pointer loss, on a payload byte and a Z5 byte.
    for (int c = 0; c < 8; c++) begin
      ctrl_m = {6'h0, c[1:0]};
      bus(1'h1, CT, ctrl_m, rd);
      rx_pointer_loss <= c[2];
      tandem_overhead_input <= 4'($urandom);
      for (int k = 0; k < 2; k++) begin
        dv = 8'($urandom);
        send(dv, 2'(k), 2'h2, 3'h0);
        `CHK("drop", model(dv, 2'(k), c[2]), got_d)
      end
    end
    rx_pointer_loss <= 1'h0;
    $display("done: stream");
    for (int c = 0; c < 4; c++) begin
      bus(1'h1, CT, {1'h0, c[0], 6'h0}, rd);
      send(8'h0, 2'h2, {c[1], 1'h0}, 3'h2);
      `CHK("invalid", !c[1], got_i[0])
      `CHK("increment", c[1] | !c[0], got_i[2])
    end
    bus(1'h1, CT, 8'h80, rd);
    send(8'h0, 2'h2, 2'h2, 3'h2);
    `CHK("early inc", 1'h0, got_i[2])
    repeat (3) send(8'h0, 2'h3, 2'h2, 3'h0);
    send(8'h0, 2'h2, 2'h2, 3'h1);
    `CHK("late dec", 1'h1, got_i[1])
    $display("done: pointer");
    // Parity of one payload byte against a B3, bit and block mode.
    for (int m = 0; m < 2; m++) begin
      bus(1'h1, CT, {2'h0, m[0], 5'h0}, rd);
      dv = 8'($urandom);
      send(8'h0, 2'h3, 2'h2, 3'h0);
      send(dv, 2'h0, 2'h2, 3'h0);
      rx_is_b3 <= 1'h1;
      send(8'h5a, 2'h0, 2'h2, 3'h0);
      rx_is_b3 <= 1'h0;
      nib = m ? 4'(dv != 8'h5a) : 4'($countones(dv ^ 8'h5a));
      `CHK("parity", nib, parity_errors)
    end
    bus(1'h1, CT, 8'h0, rd);
    bus(1'h1, rptrc_pkg::IDX_MASTER_CFG, 8'h0, rd);
    trig();
    np = 3'($urandom_range(7, 1));
    nn = 3'($urandom_range(7, 1));
    u_peer.pulse(np, nn);
    trig();
    rchk(rptrc_pkg::IDX_POS_JUST, {5'h0, np}, "pos drop");
    rchk(rptrc_pkg::IDX_NEG_JUST, {5'h0, nn}, "neg drop");
    bus(1'h1, rptrc_pkg::IDX_MASTER_CFG, 8'h1, rd);
    trig();
    send(8'h0, 2'h2, 2'h2, 3'h2);
    send(8'h0, 2'h2, 2'h2, 3'h1);
    u_peer.pulse(3'h2, 3'h2);
    trig();
    rchk(rptrc_pkg::IDX_POS_JUST, 8'h1, "pos rx");
    rchk(rptrc_pkg::IDX_NEG_JUST, 8'h1, "neg rx");
    trig();
    rchk(rptrc_pkg::IDX_POS_JUST, 8'h0, "pos restart");
    $display("done: justification");
    sum = 0;
    for (int i = 0; i < 3; i++) begin
      nib = 4'($urandom);
      sum += nib;
      send({nib, 4'h0}, 2'h1, 2'h2, 3'h0);
    end
    trig();
    rchk(rptrc_pkg::IDX_IEC_LOW, sum[7:0], "iec low");
    rchk(rptrc_pkg::IDX_IEC_HIGH, sum[15:8], "iec high");
    trig();
    rchk(rptrc_pkg::IDX_IEC_LOW, 8'h0, "iec restart");
    $display("done: incoming errors");
    bus(1'h1, MF, 8'h20, rd);
    multiframe_loss <= 1'h1;
    repeat (4) @(posedge mclk);
    `CHK("irq on", 1'h0, interrupt_out_n)
    rchk(MF, 8'he0, "mf status");
    repeat (2) @(posedge mclk);
    `CHK("irq cleared", 1'h1, interrupt_out_n)
    bus(1'h1, MF, 8'h0, rd);
    multiframe_loss <= 1'h0;
    repeat (4) @(posedge mclk);
    `CHK("irq masked", 1'h1, interrupt_out_n)
    rchk(MF, 8'h80, "mf flag");
    $display("done: multiframe");
    test_done();
  end
endmodule : tb
